// ===== rtl/pwcs_pkg.sv
// Constants and types for the port width strap decoder
package pwcs_pkg;
   localparam int NUM_PORTS = 16;

   typedef enum logic [1:0]
   {
      PWCS_MODE_ALL_X1   = 2'b00,
      PWCS_MODE_LEGACY   = 2'b01,
      PWCS_MODE_NATIVE   = 2'b10,
      PWCS_MODE_RESERVED = 2'b11
   } pwcs_mode_t;

   localparam pwcs_mode_t MODE_RST = PWCS_MODE_NATIVE;

   // Port masks per mode, bit n is port n
   localparam logic [15:0] X4_CAP_ALL_X1  = 16'h0000;
   localparam logic [15:0] X1_EN_ALL_X1   = 16'hffff;
   localparam logic [15:0] X4_CAP_LEGACY  = 16'h0041;
   localparam logic [15:0] X1_EN_LEGACY   = 16'h3c3c;
   localparam logic [15:0] X4_CAP_NATIVE  = 16'h0055;
   localparam logic [15:0] X1_EN_NATIVE   = 16'hffff;
   localparam logic [4:0]  MAX_X1_ALL_X1  = 5'h10;
   localparam logic [4:0]  MAX_X1_LEGACY  = 5'h0c;
   localparam logic [4:0]  MAX_X1_NATIVE  = 5'h10;
   localparam logic [2:0]  MAX_X4_ALL_X1  = 3'h0;
   localparam logic [2:0]  MAX_X4_LEGACY  = 3'h2;
   localparam logic [2:0]  MAX_X4_NATIVE  = 3'h4;

   // Identity value below is arbitrary
   localparam logic [11:0] DEV_ID_RST = 12'h5a1;
endpackage

// ===== rtl/pwcs_layout_rom.sv
// Combinational lookup from compatibility mode to port layout
`timescale 1ns/1ps
module pwcs_layout_rom
   import pwcs_pkg::*;
(
   // Mode in
   input  wire pwcs_pkg::pwcs_mode_t mode,
   // Layout out
   output logic [15:0]               x4_cap,
   output logic [15:0]               x1_en,
   output logic [4:0]                max_x1,
   output logic [2:0]                max_x4,
   output logic                      unsupported
);
   always_comb
   begin
      case (mode)
         PWCS_MODE_ALL_X1:
         begin
            x4_cap      = X4_CAP_ALL_X1;
            x1_en       = X1_EN_ALL_X1;
            max_x1      = MAX_X1_ALL_X1;
            max_x4      = MAX_X4_ALL_X1;
            unsupported = 1'b0;
         end
         PWCS_MODE_LEGACY:
         begin
            x4_cap      = X4_CAP_LEGACY;
            x1_en       = X1_EN_LEGACY;
            max_x1      = MAX_X1_LEGACY;
            max_x4      = MAX_X4_LEGACY;
            unsupported = 1'b0;
         end
         PWCS_MODE_NATIVE:
         begin
            x4_cap      = X4_CAP_NATIVE;
            x1_en       = X1_EN_NATIVE;
            max_x1      = MAX_X1_NATIVE;
            max_x4      = MAX_X4_NATIVE;
            unsupported = 1'b0;
         end
         default:
         begin
            // Reserved strap: no ports enabled rather than a guessed layout
            x4_cap      = 16'h0000;
            x1_en       = 16'h0000;
            max_x1      = 5'h00;
            max_x4      = 3'h0;
            unsupported = 1'b1;
         end
      endcase
   end
endmodule

// ===== rtl/pwcs_strap_decode.sv
// Top: samples compatibility straps at hard reset and drives the port layout
`timescale 1ns/1ps
module pwcs_strap_decode
   import pwcs_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // Hard reset level, held low while the board asserts hard reset
   input  wire logic        hard_rst_n,
   // Straps and pins
   input  wire logic [1:0]  comp_mode,
   input  wire logic        scan_compat_enable,
   input  wire logic        test_rst_n,
   // Layout
   output logic [15:0]      x4_capable,
   output logic [15:0]      x1_enable,
   output logic [4:0]       max_x1_ports,
   output logic [2:0]       max_x4_ports,
   output logic [1:0]       mode_latched,
   output logic             mode_unsupported,
   output logic             layout_valid,
   // Test and diagnostics
   output logic             analyser_en,
   output logic             scan_compat_active,
   output logic             tap_rst_n,
   output logic [11:0]      device_id
);
   import pwcs_pkg::*;

   // Straps are taken on every edge while hard reset is low, so only the
   // value present at release counts. The mode and the valid flag load on the
   // capture edge and the layout one edge after that; both then hold
   // until the next hard reset or power-on reset.
   // A reserved strap leaves every port disabled and raises the unsupported
   // flag rather than guessing at a layout.
   // Limitation: power-on reset alone captures nothing; a strap change needs
   // a hard reset before the new layout shows.

   // Strap capture state
   pwcs_mode_t  mode_r;
   pwcs_mode_t  mode_nxt;
   logic        valid_r;
   logic        valid_nxt;

   // Layout as decoded from the captured mode
   logic [15:0] x4_w;
   logic [15:0] x1_w;
   logic [4:0]  mx1_w;
   logic [2:0]  mx4_w;
   logic        uns_w;

   // Registered layout
   logic [15:0] x4_r;
   logic [15:0] x4_nxt;
   logic [15:0] x1_r;
   logic [15:0] x1_nxt;
   logic [4:0]  mx1_r;
   logic [4:0]  mx1_nxt;
   logic [2:0]  mx4_r;
   logic [2:0]  mx4_nxt;
   logic        uns_r;
   logic        uns_nxt;

   // Registered pin state
   logic        ana_r;
   logic        ana_nxt;
   logic        scan_r;
   logic        scan_nxt;
   logic        tap_r;
   logic        tap_nxt;

   // Identity word
   logic [11:0] id_r;
   logic [11:0] id_nxt;

   // Zero a mask until a strap has been captured
   function automatic logic [15:0] hold_off
   (
      input logic        en,
      input logic [15:0] val
   );
      hold_off = en ? val : 16'h0000;
   endfunction

   // Strap capture: follows pins while hard reset is low, frozen after release
   always_comb
   begin
      mode_nxt  = mode_r;
      valid_nxt = valid_r;
      if (!hard_rst_n)
      begin
         mode_nxt  = pwcs_mode_t'(comp_mode);
         valid_nxt = 1'b1;
      end
   end

   // Power-on reset lands on the default mode, but layout_valid stays low until a capture
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_r  <= MODE_RST;
         valid_r <= 1'b0;
      end
      else
      begin
         mode_r  <= mode_nxt;
         valid_r <= valid_nxt;
      end
   end

   // Pure lookup; the register stage behind it keeps every output on a flop
   pwcs_layout_rom u_rom
   (
      .mode        (mode_r),
      .x4_cap      (x4_w),
      .x1_en       (x1_w),
      .max_x1      (mx1_w),
      .max_x4      (mx4_w),
      .unsupported (uns_w)
   );

   // Layout held off until a strap was seen, so ports never flash a wrong width.
   // The extra stage costs one cycle of latency, which hard reset easily covers.
   always_comb
   begin
      x4_nxt  = hold_off(valid_r, x4_w);
      x1_nxt  = hold_off(valid_r, x1_w);
      mx1_nxt = 5'h00;
      mx4_nxt = 3'h0;
      uns_nxt = 1'b0;
      if (valid_r)
      begin
         mx1_nxt = mx1_w;
         mx4_nxt = mx4_w;
         uns_nxt = uns_w;
      end
   end

   // Registered layout only changes one edge after a capture
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         x4_r  <= 16'h0000;
         x1_r  <= 16'h0000;
         mx1_r <= 5'h00;
         mx4_r <= 3'h0;
         uns_r <= 1'b0;
      end
      else
      begin
         x4_r  <= x4_nxt;
         x1_r  <= x1_nxt;
         mx1_r <= mx1_nxt;
         mx4_r <= mx4_nxt;
         uns_r <= uns_nxt;
      end
   end

   // Straps are static pins taken as synchronous, so no synchroniser stage
   always_comb
   begin
      // Pin low selects the analyser; high is normal mission and scan access
      ana_nxt  = ~scan_compat_enable;
      scan_nxt = scan_compat_enable;
      // Combined reset protects the test port even if board wiring skips the gate
      tap_nxt  = hard_rst_n & test_rst_n;
   end

   // tap_rst_n is low throughout power-on reset and from the first edge after hard reset goes low, so the test port stays reset
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ana_r  <= 1'b0;
         scan_r <= 1'b0;
         tap_r  <= 1'b0;
      end
      else
      begin
         ana_r  <= ana_nxt;
         scan_r <= scan_nxt;
         tap_r  <= tap_nxt;
      end
   end

   // Identity never changes; it sits in a flop only so every output is registered
   always_comb
   begin
      id_nxt = id_r;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         id_r <= DEV_ID_RST;
      end
      else
      begin
         id_r <= id_nxt;
      end
   end

   // Layout outputs
   assign x4_capable         = x4_r;
   assign x1_enable          = x1_r;
   assign max_x1_ports       = mx1_r;
   assign max_x4_ports       = mx4_r;
   assign mode_latched       = mode_r;
   assign mode_unsupported   = uns_r;
   assign layout_valid       = valid_r;

   // Pin and identity outputs
   assign analyser_en        = ana_r;
   assign scan_compat_active = scan_r;
   assign tap_rst_n          = tap_r;
   assign device_id          = id_r;
endmodule

// ===== tb/pwcs_checker.sv
// Port assertions for the strap decoder
`timescale 1ns/1ps
module pwcs_checker
(
   // Clock, reset and pins
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        hard_rst_n,
   input wire logic [1:0]  comp_mode,
   input wire logic        scan_compat_enable,
   input wire logic        test_rst_n,
   // Layout and diagnostics
   input wire logic [15:0] x4_capable,
   input wire logic [15:0] x1_enable,
   input wire logic [4:0]  max_x1_ports,
   input wire logic [2:0]  max_x4_ports,
   input wire logic [1:0]  mode_latched,
   input wire logic        mode_unsupported,
   input wire logic        layout_valid,
   input wire logic        analyser_en,
   input wire logic        scan_compat_active,
   input wire logic        tap_rst_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic held_r;
   // Layout lags the latched mode by one edge, so judge it only once straps froze
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         held_r <= 1'b0;
      else
         held_r <= hard_rst_n;
   end
   wire ok = held_r & layout_valid;
   wire [1:0] m = mode_latched;
   wire [39:0] lay = {x4_capable, x1_enable, max_x1_ports, max_x4_ports};
   a_all_x1_layout: assert property (ok && m == 2'h0 |-> lay == 40'h0000ffff80)
      else $error("mode 00 layout");
   a_legacy_masks: assert property (ok && m == 2'h1 |-> lay[39:8] == 32'h00413c3c)
      else $error("mode 01 masks");
   a_legacy_counts: assert property (ok && m == 2'h1 |-> lay[7:0] == 8'h62)
      else $error("mode 01 counts");
   a_native_layout: assert property (ok && m == 2'h2 |-> lay == 40'h0055ffff84)
      else $error("mode 10 layout");
   a_reserved_flag: assert property (ok && m == 2'h3 |-> mode_unsupported && lay == 0)
      else $error("mode 11 not flagged");
   a_strap_capture: assert property (!hard_rst_n |=> layout_valid && m == $past(comp_mode))
      else $error("strap not captured");
   a_strap_frozen: assert property (hard_rst_n |=> $stable(m))
      else $error("mode moved");
   a_analyser_on: assert property ($past(arst_n) |->
      analyser_en == !$past(scan_compat_enable))
      else $error("analyser wrong");
   a_scan_follow: assert property ($past(arst_n) |->
      scan_compat_active == $past(scan_compat_enable))
      else $error("scan flag wrong");
   a_tap_gate: assert property ($past(arst_n) |->
      tap_rst_n == ($past(hard_rst_n) & $past(test_rst_n)))
      else $error("test reset gate wrong");
   c_legacy: cover property (ok && m == 2'h1);
   c_reserved: cover property (ok && m == 2'h3);
   c_analyser: cover property (analyser_en);
endmodule
bind pwcs_strap_decode pwcs_checker i_chk (.*);

// ===== tb/pwcs_board.sv
// Board straps and external reset logic
`timescale 1ns/1ps
module pwcs_board
(
   // Bench requests
   input wire logic hard_req_n,
   input wire logic tap_req_n,
   input wire logic diag_req_n,
   // Pins
   output logic hard_rst_n,
   output logic test_rst_n,
   output logic scan_compat_enable
);
   assign hard_rst_n = hard_req_n;
   assign test_rst_n = hard_req_n & tap_req_n;
   // Pull-up default: scan enable stays high unless diagnostics are requested
   assign scan_compat_enable = diag_req_n;
endmodule

// ===== tb/pwcs_strap_decode_tb.sv
// Self-checking bench for the strap decoder
`timescale 1ns/1ps
module pwcs_strap_decode_tb;
   logic sys_clk = 0, arst_n = 0, hard_req_n = 1, tap_req_n = 1, diag_req_n = 1;
   logic [1:0] comp_mode = 2'h2;
   logic hard_rst_n, test_rst_n, scan_compat_enable;
   logic [15:0] x4_capable, x1_enable;
   logic [4:0] max_x1_ports;
   logic [2:0] max_x4_ports;
   logic [1:0] mode_latched;
   logic mode_unsupported, layout_valid, analyser_en, scan_compat_active, tap_rst_n;
   logic [11:0] device_id;
   wire [40:0] layout = {x4_capable, x1_enable, max_x1_ports, max_x4_ports, mode_unsupported};
   wire [5:0] ctl = {layout_valid, mode_latched, analyser_en, scan_compat_active, tap_rst_n};
   int num_errors = 0, samples_checked = 0;
   always #20 sys_clk = ~sys_clk;
   pwcs_board i_board (.*);
   pwcs_strap_decode i_dut (.*);
   task automatic chk(string n, logic [40:0] e, logic [40:0] g);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic capture(logic [1:0] m);
      @(posedge sys_clk);
      comp_mode <= m;
      hard_req_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      hard_req_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic t_modes;
      logic [40:0] e [4] = '{41'h0001ffff00, 41'h00827878c4, 41'h00abffff08, 41'h1};
      for (int m = 0; m < 4; m++)
      begin
         capture(m[1:0]);
         chk("layout", e[m], layout);
      end
   endtask
   task automatic t_freeze;
      capture(2'h1);
      @(posedge sys_clk);
      comp_mode <= 2'h2;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("mode", 3'h5, {layout_valid, mode_latched});
      chk("frozen", 41'h00827878c4, layout);
   endtask
   task automatic t_pins(logic d, logic t);
      @(posedge sys_clk);
      diag_req_n <= d;
      tap_req_n <= t;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("pins", {!d, d, t}, {analyser_en, scan_compat_active, tap_rst_n});
   endtask
   task automatic t_reset;
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("reset_layout", 41'h0, layout);
      chk("reset_ctl", 6'h10, ctl);
      chk("device_id", pwcs_pkg::DEV_ID_RST, device_id);
      @(posedge sys_clk);
      arst_n <= 1'b1;
      comp_mode <= 2'h0;
      hard_req_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("tap_in_hard", 1'b0, tap_rst_n);
      @(posedge sys_clk);
      hard_req_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("relayout", 41'h0001ffff00, layout);
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_modes();
      t_freeze();
      t_pins(1'b0, 1'b0);
      t_pins(1'b1, 1'b1);
      t_reset();
      end_of_test();
   end
endmodule
